// *** hdl/bit_and_flag_instr_exec.v ***
// Purpose: executes I/O bit set/clear, rotates through carry, transfer-flag bit moves,
//          single-flag set/clear, sleep and watchdog restart, launched over APB
// Assumes: APB master on ref_clk, zero-wait slave, clk_en freezes everything
// Notes:   one operation at a time; a launch while busy is refused and flagged
// Summary of operation
// - I/O bit set forces the chosen bit of the addressed I/O word to one in two cycles.
// - I/O bit clear forces the chosen bit of the addressed I/O word to zero in two cycles.
// - Rotate left via carry shifts up, carry to bit 0, old bit 7 to carry, sets Z C N V.
// - Rotate right via carry shifts down, carry to bit 7, old bit 0 to carry, sets Z C N V.
// - Bit store copies the chosen working-register bit into the transfer flag in one cycle.
// - Bit load writes the transfer flag into the chosen working-register bit in one cycle.
// - Half-carry set and clear drive only the half-carry flag, one cycle each.
// - Overflow set and clear drive only the overflow flag, one cycle each.
// - Sign-test set and clear drive only the signed test flag, one cycle each.
// - Sleep takes three cycles, changes no flag, then hands over to power saving.
// - Watchdog restart takes one cycle, changes no flag and signals the watchdog.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "bit_flag_exec_consts.vh"

module bit_and_flag_instr_exec #(
    parameter DATA_W = 8,
    parameter IO_AW  = 3
) (
    input  wire        ref_clk,
    input  wire        reset_n,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output reg         sleep_active,
    input  wire        sleep_wake,
    output reg         wdt_restart
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_EXEC = 3'h1;
    localparam [2:0] ST_IOWR = 3'h2;
    localparam [2:0] ST_SLP2 = 3'h3;
    localparam [2:0] ST_SLP3 = 3'h4;

    reg  [2:0]        state_r;
    reg  [2:0]        state_nxt;
    reg  [3:0]        op_r;
    reg  [DATA_W-1:0] data_r;
    reg  [2:0]        bitsel_r;
    reg  [IO_AW-1:0]  ioaddr_r;
    reg  [7:0]        flags_r;
    reg  [DATA_W-1:0] io_hold_r;
    reg               refused_r;

    wire              busy;
    wire              acc;
    wire              wr;
    wire              setup;
    wire              hit;
    wire              launch;
    wire [DATA_W-1:0] io_rd_data;
    reg               io_wr_en;
    reg  [IO_AW-1:0]  io_wr_addr;
    reg  [DATA_W-1:0] io_wr_data;
    reg  [DATA_W-1:0] rot;
    reg               rot_c;
    reg  [DATA_W-1:0] bit_mask;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    // no wait states; a frozen clock stalls the master instead
    assign pready  = clk_en;
    assign busy    = (state_r != ST_IDLE);
    assign setup   = psel && !penable;
    assign acc     = psel && penable && clk_en;
    assign wr      = acc && pwrite;
    assign hit     = (paddr == `OFF_CMD) || (paddr == `OFF_OPERAND) ||
                     (paddr == `OFF_FLAGS) || (paddr == `OFF_STATUS) ||
                     (paddr == `OFF_IO_DATA);
    assign pslverr = psel && penable && !hit;
    assign launch  = wr && (paddr == `OFF_CMD) && !busy;

    // read data captured in the setup cycle so it comes from flops
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else if (clk_en && setup) begin
            if (paddr == `OFF_CMD) begin
                prdata <= {28'h0000000, op_r};
            end else if (paddr == `OFF_OPERAND) begin
                prdata <= {17'h00000, ioaddr_r, 1'b0, bitsel_r, data_r};
            end else if (paddr == `OFF_FLAGS) begin
                prdata <= {24'h000000, flags_r};
            end else if (paddr == `OFF_STATUS) begin
                prdata <= {29'h00000000, sleep_active, refused_r, busy};
            end else if (paddr == `OFF_IO_DATA) begin
                prdata <= {24'h000000, io_rd_data};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------------------------------
    // datapath helpers
    // ----------------------------------------------------------------
    // rotate results and one-hot bit mask
    always @* begin
        bit_mask = {DATA_W{1'b0}};
        bit_mask[bitsel_r] = 1'b1;
        if (op_r == `OP_ROT_R) begin
            rot   = {flags_r[`FLG_C], data_r[DATA_W-1:1]};
            rot_c = data_r[0];
        end else begin
            rot   = {data_r[DATA_W-2:0], flags_r[`FLG_C]};
            rot_c = data_r[DATA_W-1];
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // io ops need a read cycle and a write cycle; sleep burns three
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (launch) begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (op_r == `OP_IO_SET || op_r == `OP_IO_CLR) begin
                    state_nxt = ST_IOWR;
                end else if (op_r == `OP_SLEEP) begin
                    state_nxt = ST_SLP2;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IOWR: state_nxt = ST_IDLE;
            ST_SLP2: state_nxt = ST_SLP3;
            ST_SLP3: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // command and operand registers
    // ----------------------------------------------------------------
    // operands stay put while busy so a running op sees stable inputs
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            op_r     <= `OP_NOP;
            bitsel_r <= 3'h0;
            ioaddr_r <= {IO_AW{1'b0}};
        end else if (clk_en && !busy) begin
            if (launch) begin
                op_r <= pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
            end
            if (wr && paddr == `OFF_OPERAND) begin
                bitsel_r <= pwdata[`OPD_BIT_MSB:`OPD_BIT_LSB];
                ioaddr_r <= pwdata[`OPD_IO_LSB +: IO_AW];
            end
        end
    end

    // refused launch flag; a new refusal beats a clear in the same cycle
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            refused_r <= 1'b0;
        end else if (clk_en) begin
            if (wr && paddr == `OFF_CMD && busy) begin
                refused_r <= 1'b1;
            end else if (wr && paddr == `OFF_STATUS && pwdata[`STS_REFUSED]) begin
                refused_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // working register and status flags
    // ----------------------------------------------------------------
    // execution happens in the single exec cycle; software writes only when idle
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_r  <= `RST_DATA;
            flags_r <= `RST_FLAGS;
        end else if (clk_en) begin
            if (state_r == ST_EXEC) begin
                case (op_r)
                    `OP_ROT_L, `OP_ROT_R: begin
                        data_r            <= rot;
                        flags_r[`FLG_C]   <= rot_c;
                        flags_r[`FLG_Z]   <= (rot == {DATA_W{1'b0}});
                        flags_r[`FLG_N]   <= rot[DATA_W-1];
                        flags_r[`FLG_V]   <= rot[DATA_W-1] ^ rot_c;
                    end
                    `OP_T_STORE: flags_r[`FLG_T] <= data_r[bitsel_r];
                    `OP_T_LOAD: begin
                        // flags untouched, only the chosen bit moves
                        data_r <= flags_r[`FLG_T] ? (data_r | bit_mask)
                                                  : (data_r & ~bit_mask);
                    end
                    `OP_H_SET: flags_r[`FLG_H] <= 1'b1;
                    `OP_H_CLR: flags_r[`FLG_H] <= 1'b0;
                    `OP_V_SET: flags_r[`FLG_V] <= 1'b1;
                    `OP_V_CLR: flags_r[`FLG_V] <= 1'b0;
                    `OP_S_SET: flags_r[`FLG_S] <= 1'b1;
                    `OP_S_CLR: flags_r[`FLG_S] <= 1'b0;
                    default: begin
                        // io, sleep, watchdog and nop leave flags alone
                        flags_r <= flags_r;
                    end
                endcase
            end else if (!busy) begin
                if (wr && paddr == `OFF_OPERAND) begin
                    data_r <= pwdata[`OPD_DATA_MSB:`OPD_DATA_LSB];
                end
                if (wr && paddr == `OFF_FLAGS) begin
                    flags_r <= pwdata[7:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // i/o read-modify-write
    // ----------------------------------------------------------------
    // first cycle reads the location, second writes it back modified
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            io_hold_r <= `RST_IO;
        end else if (clk_en && state_r == ST_EXEC) begin
            io_hold_r <= io_rd_data;
        end
    end

    always @* begin
        io_wr_en   = 1'b0;
        io_wr_addr = ioaddr_r;
        io_wr_data = io_hold_r;
        if (state_r == ST_IOWR) begin
            io_wr_en = 1'b1;
            if (op_r == `OP_IO_SET) begin
                io_wr_data = io_hold_r | bit_mask;
            end else begin
                io_wr_data = io_hold_r & ~bit_mask;
            end
        end else if (wr && paddr == `OFF_IO_DATA && !busy) begin
            io_wr_en   = 1'b1;
            io_wr_data = pwdata[DATA_W-1:0];
        end
    end

    io_bit_space #(
        .WIDTH (DATA_W),
        .AW    (IO_AW)
    ) u_io (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .rd_addr (ioaddr_r),
        .rd_data (io_rd_data),
        .wr_en   (io_wr_en),
        .wr_addr (io_wr_addr),
        .wr_data (io_wr_data)
    );

    // ----------------------------------------------------------------
    // power and watchdog hand-off
    // ----------------------------------------------------------------
    // sleep level rises after the third cycle and holds until a wake arrives;
    // a wake in the same cycle as entry loses, so sleep is never skipped
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_active <= 1'b0;
            wdt_restart  <= 1'b0;
        end else if (clk_en) begin
            if (state_r == ST_SLP3) begin
                sleep_active <= 1'b1;
            end else if (sleep_wake) begin
                sleep_active <= 1'b0;
            end
            wdt_restart <= (state_r == ST_EXEC) && (op_r == `OP_WDOG);
        end
    end

endmodule // bit_and_flag_instr_exec

// *** hdl/bit_flag_exec_consts.vh ***
// Purpose: offsets, field positions, codes and reset values of the bit and flag executor
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef BIT_FLAG_EXEC_CONSTS_VH
`define BIT_FLAG_EXEC_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CMD          8'h00
`define OFF_OPERAND      8'h04
`define OFF_FLAGS        8'h08
`define OFF_STATUS       8'h0C
`define OFF_IO_DATA      8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMD_OP_LSB       0
`define CMD_OP_MSB       3
`define OPD_DATA_LSB     0
`define OPD_DATA_MSB     7
`define OPD_BIT_LSB      8
`define OPD_BIT_MSB      10
`define OPD_IO_LSB       12
`define STS_BUSY         0
`define STS_REFUSED      1
`define STS_SLEEP        2
// status flag positions
`define FLG_C            0
`define FLG_Z            1
`define FLG_N            2
`define FLG_V            3
`define FLG_S            4
`define FLG_H            5
`define FLG_T            6
`define FLG_I            7

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define OP_NOP           4'h0
`define OP_IO_SET        4'h1
`define OP_IO_CLR        4'h2
`define OP_ROT_L         4'h3
`define OP_ROT_R         4'h4
`define OP_T_STORE       4'h5
`define OP_T_LOAD        4'h6
`define OP_H_SET         4'h7
`define OP_H_CLR         4'h8
`define OP_V_SET         4'h9
`define OP_V_CLR         4'hA
`define OP_S_SET         4'hB
`define OP_S_CLR         4'hC
`define OP_SLEEP         4'hD
`define OP_WDOG          4'hE

// ----------------------------------------------------------------
// cycle counts and reset values
// ----------------------------------------------------------------
`define CYC_IO_BIT       2
`define CYC_SLEEP        3
`define CYC_SINGLE       1
`define RST_FLAGS        8'h00
`define RST_DATA         8'h00
`define RST_IO           8'h00

`endif

// *** hdl/io_bit_space.v ***
// Purpose: small I/O location store, one word per index
// Assumes: same clock as the executor, synchronous write, flop read
// Notes:   storage is flip-flops, one generate entry per location
`timescale 1ns/1ps
`include "bit_flag_exec_consts.vh"

module io_bit_space #(
    parameter WIDTH = 8,
    parameter AW    = 3
) (
    input  wire             ref_clk,
    input  wire             reset_n,
    input  wire             clk_en,
    input  wire [AW-1:0]    rd_addr,
    output wire [WIDTH-1:0] rd_data,
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_addr,
    input  wire [WIDTH-1:0] wr_data
);

    localparam DEPTH = 1 << AW;

    wire [WIDTH*DEPTH-1:0] flat;

    // ----------------------------------------------------------------
    // storage entries
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_loc
            reg [WIDTH-1:0] loc_r;
            // each entry loads only when addressed and clock enabled
            always @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    loc_r <= `RST_IO;
                end else if (clk_en && wr_en && (wr_addr == i)) begin
                    loc_r <= wr_data;
                end
            end
            assign flat[i*WIDTH +: WIDTH] = loc_r;
        end
    endgenerate

    // read straight from the flops by index
    assign rd_data = flat[rd_addr*WIDTH +: WIDTH];

endmodule // io_bit_space

// *** tb/bit_flag_exec_asserts.sv ***
// Purpose: port-level checks of the bit and flag executor
// Assumes: zero-wait APB while clk_en is high, sleep_wake low around sleep entry
// Notes:   bound to every instance of the executor
`timescale 1ns/1ps
`include "bit_flag_exec_consts.vh"

module bit_flag_exec_asserts (
    input wire        ref_clk,
    input wire        reset_n,
    input wire        clk_en,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        sleep_active,
    input wire        sleep_wake,
    input wire        wdt_restart
);
    // ----------------------------------------------------------------
    // launch decode
    // ----------------------------------------------------------------
    wire take   = psel && penable && clk_en;
    wire go_cmd = take && pwrite && (paddr == `OFF_CMD);
    wire go_wdt = go_cmd && (pwdata[3:0] == `OP_WDOG);
    wire go_slp = go_cmd && (pwdata[3:0] == `OP_SLEEP);
    wire mapped = (paddr == `OFF_CMD) || (paddr == `OFF_OPERAND) || (paddr == `OFF_FLAGS)
                  || (paddr == `OFF_STATUS) || (paddr == `OFF_IO_DATA);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------------------------------
    // bus, watchdog and sleep relations
    // ----------------------------------------------------------------
    a_ready_follows_en: assert property (pready == clk_en)
        else $error("pready differs from clk_en");
    a_err_on_unmapped: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr does not match the address map");
    a_rd_upper_zero: assert property (take && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_wdt_after_op: assert property (go_wdt |-> ##1 !wdt_restart ##1 wdt_restart)
        else $error("watchdog pulse not two edges after launch");
    a_wdt_one_pulse: assert property (wdt_restart |=> !wdt_restart)
        else $error("watchdog pulse longer than one cycle");
    a_wdt_has_cause: assert property (wdt_restart |-> $past(go_wdt, 2))
        else $error("watchdog pulse without launch");
    a_sleep_three_cyc: assert property (go_slp && !sleep_active |->
                                        ##1 (!sleep_active)[*3] ##1 sleep_active)
        else $error("sleep entry not after three cycles");
    a_sleep_level_holds: assert property (sleep_active && !sleep_wake && clk_en
                                          |=> sleep_active)
        else $error("sleep level dropped without wake");
    a_wake_clears: assert property (sleep_active && sleep_wake && clk_en && !go_slp |=> !sleep_active)
        else $error("wake did not clear sleep level");
    a_freeze_holds: assert property (!clk_en |=> $stable(sleep_active) && $stable(wdt_restart))
        else $error("state moved while clock enable low");
endmodule // bit_flag_exec_asserts

bind bit_and_flag_instr_exec bit_flag_exec_asserts u_bit_flag_exec_asserts (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_active(sleep_active), .sleep_wake(sleep_wake),
    .wdt_restart(wdt_restart)
);

// *** tb/tb_top.sv ***
// Purpose: directed APB tests of the bit and flag executor
// Assumes: register map and op codes of the shared constants header
// Notes:   busy is polled over APB, so cycle counts are seen as half as many busy reads, rounded down
`timescale 1ns/1ps
`include "bit_flag_exec_consts.vh"

module tb_top;
    reg         ref_clk, reset_n, clk_en, psel, penable, pwrite, sleep_wake, c;
    reg  [7:0]  paddr, s_exp, d_exp, m;
    reg  [31:0] pwdata, rdata;
    reg         rerr;
    reg  [8:0]  rot_in [0:3];
    wire [31:0] prdata;
    wire        pready, pslverr, sleep_active, wdt_restart;
    integer     mismatches, comparisons, wdt_pulses, i, nbusy;

    bit_and_flag_instr_exec #(.DATA_W(8), .IO_AW(3)) u_bit_and_flag_instr_exec (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_active(sleep_active), .sleep_wake(sleep_wake),
        .wdt_restart(wdt_restart));

    // ----------------------------------------------------------------
    // clock, pulse monitor, watchdog
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (wdt_restart === 1'b1) wdt_pulses <= wdt_pulses + 1;
    // generous: the sequence needs far fewer than 12500 cycles
    initial begin
        #100000;
        mismatches = mismatches + 1;
        $display("[FAIL] run expected done seen timeout");
        wrap_up;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // one transfer; waits for pready, bounded so a stuck slave cannot hang us
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge ref_clk);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge ref_clk);
            penable <= 1'b1;
            n = 0;
            @(posedge ref_clk);
            while (pready !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge ref_clk);
            end
            rdata = prdata;
            rerr  = pslverr;
            check("pready wait", n < 50, 1);
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd_chk(input string what, input [7:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0000_0000);
            check(what, rdata, exp);
        end
    endtask
    // launch, then count status reads that still show busy
    task op(input [3:0] code, input integer cyc);
        integer k;
        begin
            apb(1'b1, `OFF_CMD, {28'h000_0000, code});
            nbusy = 0;
            k = 0;
            apb(1'b0, `OFF_STATUS, 32'h0000_0000);
            while (rdata[`STS_BUSY] === 1'b1 && k < 10) begin
                nbusy = nbusy + 1;
                k = k + 1;
                apb(1'b0, `OFF_STATUS, 32'h0000_0000);
            end
            check("busy reads", nbusy, cyc / 2);
        end
    endtask
    task wake;
        begin
            @(posedge ref_clk) sleep_wake <= 1'b1;
            @(posedge ref_clk) sleep_wake <= 1'b0;
            @(posedge ref_clk);
            check("wake", sleep_active, 1'b0);
        end
    endtask
    task wrap_up;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, sleep_wake, reset_n} = 5'b00000;
        {paddr, pwdata} = 40'h00_0000_0000;
        clk_en = 1'b1;
        {mismatches, comparisons, wdt_pulses} = 0;
        rot_in[0] = 9'h080;
        rot_in[1] = 9'h101;
        rot_in[2] = 9'h155;
        rot_in[3] = 9'h000;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd_chk("flags reset", `OFF_FLAGS, 32'h0000_0000);
        rd_chk("operand reset", `OFF_OPERAND, 32'h0000_0000);
        rd_chk("status reset", `OFF_STATUS, 32'h0000_0000);
        rd_chk("io reset", `OFF_IO_DATA, 32'h0000_0000);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check("unmapped err", rerr, 1'b1);
        // io location 5, bit 3
        apb(1'b1, `OFF_FLAGS, 32'h0000_005A);
        apb(1'b1, `OFF_OPERAND, 32'h0000_5300);
        op(`OP_IO_SET, `CYC_IO_BIT);
        rd_chk("io set", `OFF_IO_DATA, 32'h0000_0008);
        apb(1'b1, `OFF_IO_DATA, 32'h0000_00FF);
        op(`OP_IO_CLR, `CYC_IO_BIT);
        rd_chk("io clear", `OFF_IO_DATA, 32'h0000_00F7);
        rd_chk("io flags", `OFF_FLAGS, 32'h0000_005A);
        apb(1'b1, `OFF_OPERAND, 32'h0000_6300);
        rd_chk("io neighbour", `OFF_IO_DATA, 32'h0000_0000);
        // rotates: first four left, last four right, H S T preset to show they stay
        for (i = 0; i < 8; i = i + 1) begin
            d_exp = rot_in[i % 4][7:0];
            s_exp = 8'h7E | {7'h00, rot_in[i % 4][8]};
            apb(1'b1, `OFF_OPERAND, {24'h00_0000, d_exp});
            apb(1'b1, `OFF_FLAGS, {24'h00_0000, s_exp});
            op((i < 4) ? `OP_ROT_L : `OP_ROT_R, `CYC_SINGLE);
            c = (i < 4) ? d_exp[7] : d_exp[0];
            d_exp = (i < 4) ? {d_exp[6:0], s_exp[0]} : {s_exp[0], d_exp[7:1]};
            s_exp[`FLG_C] = c;
            s_exp[`FLG_Z] = (d_exp == 8'h00);
            s_exp[`FLG_N] = d_exp[7];
            s_exp[`FLG_V] = d_exp[7] ^ c;
            apb(1'b0, `OFF_OPERAND, 32'h0000_0000);
            check("rotate data", {24'h00_0000, rdata[7:0]}, {24'h00_0000, d_exp});
            rd_chk("rotate flags", `OFF_FLAGS, {24'h00_0000, s_exp});
        end
        // transfer flag moves
        apb(1'b1, `OFF_FLAGS, 32'h0000_003F);
        apb(1'b1, `OFF_OPERAND, 32'h0000_02A5);
        op(`OP_T_STORE, `CYC_SINGLE);
        rd_chk("t from bit", `OFF_FLAGS, 32'h0000_007F);
        apb(1'b1, `OFF_OPERAND, 32'h0000_0700);
        op(`OP_T_LOAD, `CYC_SINGLE);
        rd_chk("bit from t", `OFF_OPERAND, 32'h0000_0780);
        apb(1'b1, `OFF_OPERAND, 32'h0000_01A5);
        op(`OP_T_STORE, `CYC_SINGLE);
        rd_chk("t cleared", `OFF_FLAGS, 32'h0000_003F);
        apb(1'b1, `OFF_OPERAND, 32'h0000_00FF);
        op(`OP_T_LOAD, `CYC_SINGLE);
        rd_chk("bit cleared", `OFF_OPERAND, 32'h0000_00FE);
        rd_chk("load flags", `OFF_FLAGS, 32'h0000_003F);
        // single-flag ops, preset so the target bit always flips
        for (i = 7; i <= 12; i = i + 1) begin
            m = (i < 9) ? 8'h20 : ((i < 11) ? 8'h08 : 8'h10);
            s_exp = (i % 2) ? (8'hC3 & ~m) : (8'h3C | m);
            apb(1'b1, `OFF_FLAGS, {24'h00_0000, s_exp});
            op(i[3:0], `CYC_SINGLE);
            s_exp = (i % 2) ? (s_exp | m) : (s_exp & ~m);
            rd_chk("single flag", `OFF_FLAGS, {24'h00_0000, s_exp});
        end
        // sleep, wake, watchdog restart
        apb(1'b1, `OFF_FLAGS, 32'h0000_0096);
        op(`OP_SLEEP, `CYC_SLEEP);
        check("sleep level", sleep_active, 1'b1);
        rd_chk("sleep status", `OFF_STATUS, 32'h0000_0004);
        rd_chk("sleep flags", `OFF_FLAGS, 32'h0000_0096);
        wake;
        op(`OP_WDOG, `CYC_SINGLE);
        check("wdt pulses", wdt_pulses, 1);
        rd_chk("wdt flags", `OFF_FLAGS, 32'h0000_0096);
        // launch while busy is refused and must not touch the flags
        apb(1'b1, `OFF_CMD, {28'h000_0000, `OP_SLEEP});
        apb(1'b1, `OFF_CMD, {28'h000_0000, `OP_H_SET});
        apb(1'b0, `OFF_STATUS, 32'h0000_0000);
        check("refused", rdata[`STS_REFUSED], 1'b1);
        repeat (4) @(posedge ref_clk);
        wake;
        rd_chk("refused flags", `OFF_FLAGS, 32'h0000_0096);
        apb(1'b1, `OFF_STATUS, 32'h0000_0002);
        rd_chk("refused clear", `OFF_STATUS, 32'h0000_0000);
        // clock enable low holds the bus off
        @(posedge ref_clk) clk_en <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("frozen ready", pready, 1'b0);
        clk_en <= 1'b1;
        wrap_up;
    end
endmodule // tb_top
